/* File: core/stme_exec.sv */
// Purpose: subroutine, timer-register and misc instruction execution
// Assumes: decoder presents a request for one instruction cycle until req_taken
// Notes: one instruction cycle is 64 sys_clk periods
// Contract
// RULE1: call takes two cycles: bump stack, save pc, load 10-bit target.
// RULE2: stack increment carry on call forces internal reset.
// RULE3: return takes one cycle: pc from return register, then stack decrements.
// RULE4: stack decrement borrow on return forces internal reset.
// RULE5: memory has 1K pages, page select extends call target.
// RULE6: timer nibble reads give t9..t6 high, t5..t2 low.
// RULE7: nibble writes load t9..t6 clear t1, or t5..t2 clear t0.
// RULE8: immediate timer load writes all ten bits in one cycle.
// RULE9: interval is (value plus one) times 64 or 128 clocks.
// RULE10: table load copies rom word addressed by page control and pointer pair.
// RULE11: halt enters standby, operand selects release condition; the code skips standby while the status flag is set.
// RULE12: status test sets flag if any masked status matches, else clears.
// RULE13: all-ones test sets carry when accumulator is fh, else clears.
// RULE14: one instruction cycle is 64 clocks.
//
`include "stme_map.svh"
`timescale 1ns/1ps
`default_nettype none
module stme_exec #(
    parameter int CYC = `STME_CYC_PER_INSN,
    parameter int PAGE_BITS = 1
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // request from decoder
    input wire logic req_valid,
    input wire stme_pkg::stme_req_s req,
    input wire logic [PAGE_BITS-1:0] page_sel,
    input wire logic [2:0] table_page_ctrl,
    input wire logic [7:0] table_pointer_pair,
    input wire logic [3:0] status_in,
    input wire logic timer_clk_slow,
    input wire logic wake_event,
    // results
    output logic req_taken,
    output logic [PAGE_BITS+9:0] program_counter,
    output logic stack_pointer,
    output logic [PAGE_BITS+9:0] return_address_reg,
    output logic carry_flag,
    output logic status_flag,
    output logic acc_we,
    output logic [3:0] acc_out,
    output logic [9:0] timer_reg,
    output logic [17:0] timer_interval_clks,
    output logic timer_reload,
    output logic [PAGE_BITS+9:0] rom_addr,
    output logic standby,
    output logic [3:0] wake_sel,
    output logic int_reset
);
    // =====================================================
    // elaboration checks
    // the page field rides above the 10-bit address; the pc widens with it, and 1 to 4 page bits are allowed
    if (PAGE_BITS < 1 || PAGE_BITS > 4)
    begin
        $error("bad page width");
    end
    // the tick divider needs at least two clocks per instruction cycle
    if (CYC < 2)
    begin
        $error("instruction cycle too short");
    end
    // =====================================================
    // state
    localparam int PW = PAGE_BITS + 10;
    // sequencing state
    stme_pkg::stme_state_e st_r;
    stme_pkg::stme_state_e st_nxt;
    // program counter and the single return address slot
    logic [PW-1:0] pc_r;
    logic [PW-1:0] pc_nxt;
    logic [PW-1:0] asr_r;
    logic [PW-1:0] asr_nxt;
    // call target held over the second instruction cycle
    logic [PW-1:0] tgt_r;
    logic [PW-1:0] tgt_nxt;
    // table address toward program memory
    logic [PW-1:0] ra_r;
    logic [PW-1:0] ra_nxt;
    // one-bit stack pointer: one level only
    logic sp_r;
    logic sp_nxt;
    // carry and status flags
    logic cy_r;
    logic cy_nxt;
    logic f_r;
    logic f_nxt;
    // accumulator write-back
    logic we_r;
    logic we_nxt;
    logic [3:0] acc_r;
    logic [3:0] acc_nxt;
    // request accepted pulse
    logic tk_r;
    logic tk_nxt;
    // timer register and its interval in clocks
    logic [9:0] t_r;
    logic [9:0] t_nxt;
    logic [17:0] iv_r;
    logic [17:0] iv_nxt;
    logic rl_r;
    logic rl_nxt;
    // standby and its release selection
    logic sb_r;
    logic sb_nxt;
    logic [3:0] ws_r;
    logic [3:0] ws_nxt;
    // internal reset pulse
    logic ir_r;
    logic ir_nxt;
    // instruction cycle strobe
    logic tick;
    // =====================================================
    // instruction cycle pacing
    stme_tick #(.PERIOD(CYC)) u_tick ( // [RULE14]
        .sys_clk(sys_clk),
        .srst(srst),
        .tick(tick)
    );
    // =====================================================
    // execution next state
    always_comb
    begin
        st_nxt = st_r;
        pc_nxt = pc_r;
        asr_nxt = asr_r;
        tgt_nxt = tgt_r;
        sp_nxt = sp_r;
        cy_nxt = cy_r;
        f_nxt = f_r;
        we_nxt = 1'b0;
        acc_nxt = acc_r;
        t_nxt = t_r;
        rl_nxt = 1'b0;
        sb_nxt = sb_r;
        ws_nxt = ws_r;
        ir_nxt = 1'b0;
        tk_nxt = 1'b0;
        // table address formed continuously for the rom port
        ra_nxt = PW'({table_page_ctrl, table_pointer_pair}); // [RULE10]
        // the timer clock is a fixed divide of sys_clk; it must not follow a shortened CYC,
        // otherwise a simulation build would report intervals the silicon never produces
        iv_nxt = (18'(t_r) + 18'h1) * (timer_clk_slow ? 18'(`STME_TMR_SLOW_MUL) : 18'(`STME_TMR_FAST_MUL)); // [RULE9]
        // wake releases standby whatever else happens this clock
        if (sb_r && wake_event)
            sb_nxt = 1'b0;
        case (st_r)
            stme_pkg::ST_IDLE:
            begin
                if (tick && req_valid && !sb_r)
                begin
                    tk_nxt = 1'b1;
                    case (req.op)
                        `STME_OP_CALL:
                        begin
                            // single-level stack: a second push carries out
                            if (sp_r == 1'b1)
                                ir_nxt = 1'b1; // [RULE2]
                            else
                            begin
                                sp_nxt = 1'b1; // [RULE1]
                                asr_nxt = pc_r;
                                tgt_nxt = {page_sel, req.operand}; // [RULE5]
                                st_nxt = stme_pkg::ST_CALL2;
                            end
                        end
                        `STME_OP_RET:
                        begin
                            pc_nxt = asr_r; // [RULE3]
                            if (sp_r == 1'b0)
                                ir_nxt = 1'b1; // [RULE4]
                            else
                                sp_nxt = 1'b0;
                        end
                        `STME_OP_RD_THI:
                        begin
                            acc_nxt = t_r[9:6]; // [RULE6]
                            we_nxt = 1'b1;
                        end
                        `STME_OP_RD_TLO:
                        begin
                            acc_nxt = t_r[5:2]; // [RULE6]
                            we_nxt = 1'b1;
                        end
                        `STME_OP_WR_THI:
                        begin
                            t_nxt = {req.acc, t_r[5:2], 1'b0, t_r[0]}; // [RULE7]
                            rl_nxt = 1'b1;
                        end
                        `STME_OP_WR_TLO:
                        begin
                            t_nxt = {t_r[9:6], req.acc, t_r[1], 1'b0}; // [RULE7]
                            rl_nxt = 1'b1;
                        end
                        `STME_OP_LD_TIMM:
                        begin
                            t_nxt = req.operand; // [RULE8]
                            rl_nxt = 1'b1;
                        end
                        `STME_OP_LD_TTBL:
                        begin
                            t_nxt = req.rom_word; // [RULE10]
                            rl_nxt = 1'b1;
                        end
                        `STME_OP_HALT:
                        begin
                            // a set status flag suppresses the halt
                            if (!f_r)
                            begin
                                sb_nxt = 1'b1; // [RULE11]
                                ws_nxt = req.operand[3:0];
                            end
                        end
                        `STME_OP_STATUS_TEST_OP_REG:
                            f_nxt = |(status_in & req.reg_val); // [RULE12]
                        `STME_OP_STATUS_TEST_OP_IMM:
                            f_nxt = |(status_in & req.operand[3:0]); // [RULE12]
                        `STME_OP_ALL_ONES_TEST_OP:
                            cy_nxt = (req.acc == `STME_ALL_ONES); // [RULE13]
                        default:
                            ;
                    endcase
                end
            end
            stme_pkg::ST_CALL2:
            begin
                // second instruction cycle of the call
                if (tick)
                begin
                    pc_nxt = tgt_r; // [RULE1]
                    st_nxt = stme_pkg::ST_IDLE;
                end
            end
            default:
                st_nxt = stme_pkg::ST_IDLE;
        endcase
    end
    // =====================================================
    // registers; internal reset returns every register here to power-up state, but the tick divider keeps counting
    always_ff @(posedge sys_clk)
    begin
        if (srst || ir_r)
        begin
            st_r <= stme_pkg::ST_IDLE;
            pc_r <= PW'(`STME_PC_RST);
            asr_r <= '0;
            tgt_r <= '0;
            sp_r <= `STME_SP_RST;
            cy_r <= 1'b0;
            f_r <= 1'b0;
            we_r <= 1'b0;
            acc_r <= 4'h0;
            t_r <= 10'h000;
            iv_r <= 18'h00000;
            rl_r <= 1'b0;
            sb_r <= 1'b0;
            ws_r <= 4'h0;
            ir_r <= 1'b0;
            tk_r <= 1'b0;
            ra_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
            pc_r <= pc_nxt;
            asr_r <= asr_nxt;
            tgt_r <= tgt_nxt;
            sp_r <= sp_nxt;
            cy_r <= cy_nxt;
            f_r <= f_nxt;
            we_r <= we_nxt;
            acc_r <= acc_nxt;
            t_r <= t_nxt;
            iv_r <= iv_nxt;
            rl_r <= rl_nxt;
            sb_r <= sb_nxt;
            ws_r <= ws_nxt;
            ir_r <= ir_nxt;
            tk_r <= tk_nxt;
            ra_r <= ra_nxt;
        end
    end
    // =====================================================
    // outputs straight from flops
    assign req_taken = tk_r;
    assign program_counter = pc_r;
    assign stack_pointer = sp_r;
    assign return_address_reg = asr_r;
    assign carry_flag = cy_r;
    assign status_flag = f_r;
    assign acc_we = we_r;
    assign acc_out = acc_r;
    assign timer_reg = t_r;
    assign timer_interval_clks = iv_r;
    assign timer_reload = rl_r;
    assign rom_addr = ra_r;
    assign standby = sb_r;
    assign wake_sel = ws_r;
    assign int_reset = ir_r;
endmodule
`default_nettype wire

/* File: core/stme_map.svh */
// Purpose: constants for the subroutine/timer/misc execution unit
// Assumes: 10-bit instruction words, 4-bit accumulator
// Notes: opcodes of this unit's group are coded locally
`ifndef STME_MAP_SVH
`define STME_MAP_SVH
// =====================================================
// timing
`define STME_CYC_PER_INSN 64
`define STME_TMR_SLOW_MUL 128
`define STME_TMR_FAST_MUL 64
// =====================================================
// opcode selects
`define STME_OP_NOP 4'h0
`define STME_OP_CALL 4'h1
`define STME_OP_RET 4'h2
`define STME_OP_RD_TLO 4'h3
`define STME_OP_RD_THI 4'h4
`define STME_OP_WR_TLO 4'h5
`define STME_OP_WR_THI 4'h6
`define STME_OP_LD_TIMM 4'h7
`define STME_OP_LD_TTBL 4'h8
`define STME_OP_HALT 4'h9
`define STME_OP_STATUS_TEST_OP_REG 4'ha
`define STME_OP_STATUS_TEST_OP_IMM 4'hb
`define STME_OP_ALL_ONES_TEST_OP 4'hc
// =====================================================
// reset values and fields
`define STME_ALL_ONES 4'hf
`define STME_PC_RST 10'h000
`define STME_SP_RST 1'h0
`define STME_PAGE_LSB 10
`endif

/* File: core/stme_pkg.sv */
// Purpose: types for the execution unit
// Assumes: nothing
// Notes: request carrier from the decoder
package stme_pkg;
    // =====================================================
    // request struct
    typedef struct packed {
        logic [3:0] op;
        logic [9:0] operand;
        logic [3:0] acc;
        logic [3:0] reg_val;
        logic [9:0] rom_word;
    } stme_req_s;
    typedef enum logic [1:0] {ST_IDLE, ST_CALL2, ST_HOLD} stme_state_e;
endpackage

/* File: core/stme_tick.sv */
// Purpose: instruction-cycle tick divider
// Assumes: sys_clk 50 MHz
// Notes: one pulse per PERIOD clocks
`timescale 1ns/1ps
`default_nettype none
module stme_tick #(parameter int PERIOD = 64)
(
    // clock
    input wire logic sys_clk,
    input wire logic srst,
    // tick
    output logic tick
);
    // a one-clock period would leave the counter with no bits
    if (PERIOD < 2)
    begin
        $error("period too small");
    end
    localparam int CW = $clog2(PERIOD);
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic tick_r, tick_nxt;
    // =====================================================
    // count next state
    always_comb
    begin
        tick_nxt = (cnt_r == CW'(PERIOD-1));
        cnt_nxt = tick_nxt ? '0 : cnt_r + 1'b1;
    end
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            cnt_r <= '0;
            tick_r <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end
    assign tick = tick_r;
endmodule
`default_nettype wire

/* File: bench/stme_exec_assertions.sv */
// Purpose: port checks for stme_exec
// Assumes: srst synchronous active high, CYC at least 4
// Notes: bound to every stme_exec instance
`include "stme_map.svh"
`timescale 1ns/1ps
`default_nettype none
module stme_exec_sva #(parameter int PAGE_BITS = 1)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // inputs
    input wire stme_pkg::stme_req_s req,
    input wire logic [3:0] status_in,
    input wire logic timer_clk_slow,
    // results
    input wire logic req_taken,
    input wire logic [PAGE_BITS+9:0] program_counter,
    input wire logic stack_pointer,
    input wire logic [PAGE_BITS+9:0] return_address_reg,
    input wire logic carry_flag,
    input wire logic status_flag,
    input wire logic acc_we,
    input wire logic [3:0] acc_out,
    input wire logic [9:0] timer_reg,
    input wire logic [17:0] timer_interval_clks,
    input wire logic standby,
    input wire logic int_reset
);
    // =========================================
    // request as it stood at the taking edge
    stme_pkg::stme_req_s rq;
    always_ff @(posedge sys_clk) rq <= req;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    // =========================================
    // checks
    AST_SPACING: assert property (req_taken |=> !req_taken [*3])
        else $error("instructions too close");
    AST_CALL_SAVE:
        assert property (req_taken && rq.op == `STME_OP_CALL && !$past(stack_pointer)
        |-> stack_pointer && return_address_reg == $past(program_counter)) else $error("call save");
    AST_CALL_OVF:
        assert property (req_taken && rq.op == `STME_OP_CALL && $past(stack_pointer) |-> ##[0:2] int_reset)
        else $error("no reset on carry");
    AST_RET_LOAD:
        assert property (req_taken && rq.op == `STME_OP_RET && $past(stack_pointer)
        |-> !stack_pointer && program_counter == $past(return_address_reg)) else $error("return");
    AST_RET_UNF:
        assert property (req_taken && rq.op == `STME_OP_RET && !$past(stack_pointer) |-> ##[0:2] int_reset)
        else $error("no reset on borrow");
    AST_NIB_RD:
        assert property (req_taken && rq.op == `STME_OP_RD_THI |-> acc_we && acc_out == $past(timer_reg[9:6]))
        else $error("high nibble read");
    AST_NIB_WR:
        assert property (req_taken && rq.op == `STME_OP_WR_TLO
        |-> timer_reg[5:2] == rq.acc && !timer_reg[0] && timer_reg[9:6] == $past(timer_reg[9:6]))
        else $error("low nibble write");
    // the interval trails the timer by one clock; skip edges touched by a reset
    AST_INTERVAL:
        assert property (!$past(srst) && !$past(int_reset) && !$past(int_reset, 2) |-> timer_interval_clks
        == ({8'h00, $past(timer_reg)} + 18'h00001) << ($past(timer_clk_slow) ? 7 : 6)) else $error("interval");
    AST_ALL_ONES_TEST_OP:
        assert property (req_taken && rq.op == `STME_OP_ALL_ONES_TEST_OP |-> carry_flag == (rq.acc == `STME_ALL_ONES))
        else $error("all-ones carry");
    AST_STATUS_TEST_OP:
        assert property (req_taken && rq.op == `STME_OP_STATUS_TEST_OP_IMM
        |-> status_flag == |($past(status_in) & rq.operand[3:0])) else $error("status test");
    AST_REFUSE: assert property (standby && $past(standby) |-> !req_taken)
        else $error("taken in standby");
endmodule
bind stme_exec stme_exec_sva #(.PAGE_BITS(PAGE_BITS)) chk_u (.sys_clk, .srst, .req, .status_in, .timer_clk_slow,
    .req_taken, .program_counter, .stack_pointer, .return_address_reg, .carry_flag, .status_flag, .acc_we,
    .acc_out, .timer_reg, .timer_interval_clks, .standby, .int_reset);
`default_nettype wire

/* File: bench/tb_top.sv */
// Purpose: directed bench for stme_exec
// Assumes: CYC shortened to 4, PAGE_BITS 1
// Notes: one task per scenario, inputs move on the rising edge
`include "stme_map.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // =========================================
    // stimulus and results
    logic sys_clk = 1'b0, srst = 1'b1, req_valid = 1'b0, page_sel = 1'b1, timer_clk_slow = 1'b0, wake_event = 1'b0;
    logic req_taken, stack_pointer, carry_flag, status_flag, acc_we, timer_reload, standby, int_reset;
    logic seen_we, seen_rl, seen_rs;
    logic [2:0] table_page_ctrl = 3'h5;
    logic [7:0] table_pointer_pair = 8'h9c;
    logic [3:0] status_in = 4'h0, acc_out, wake_sel;
    logic [9:0] timer_reg;
    logic [10:0] program_counter, return_address_reg, rom_addr;
    logic [17:0] timer_interval_clks;
    stme_pkg::stme_req_s req = '0;
    int error_cnt = 0, tests_run = 0;
    // short instruction cycle keeps the run brief
    stme_exec #(.CYC(4)) dut_u (.sys_clk, .srst, .req_valid, .req, .page_sel, .table_page_ctrl,
        .table_pointer_pair, .status_in, .timer_clk_slow, .wake_event, .req_taken, .program_counter,
        .stack_pointer, .return_address_reg, .carry_flag, .status_flag, .acc_we, .acc_out, .timer_reg,
        .timer_interval_clks, .timer_reload, .rom_addr, .standby, .wake_sel, .int_reset);
    // free-running clock
    always #10 sys_clk = ~sys_clk;
    // =========================================
    // shared tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        $display("errors %0d checks %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // hold one request until taken, note the one-cycle pulses
    task automatic issue(input logic [3:0] op, input logic [9:0] opd, input logic [3:0] a);
        int n;
        n = 0;
        @(posedge sys_clk);
        req <= '{op, opd, a, a, opd};
        req_valid <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        while (req_taken !== 1'b1 && n < 99);
        check(n < 99, 1'b1);
        seen_we = acc_we;
        seen_rl = timer_reload;
        seen_rs = int_reset;
        @(posedge sys_clk);
        req_valid <= 1'b0;
        #1;
    endtask
    // reset may trail the pulse, so look a few cycles on
    task automatic chk_rst;
        repeat (3)
        begin
            @(posedge sys_clk);
            #1;
            seen_rs |= int_reset;
        end
        check(seen_rs, 1'b1);
        check({stack_pointer, program_counter}, 12'h000);
    endtask
    // =========================================
    // scenarios
    task automatic t_stack;
        issue(`STME_OP_CALL, 10'h2a5, 4'h0);
        check({seen_rs, stack_pointer, return_address_reg}, 13'h0800);
        // the target lands at the next instruction-cycle tick, four clocks after taking
        repeat (3) @(posedge sys_clk);
        #1;
        check(program_counter, 11'h6a5);
        issue(`STME_OP_RET, 10'h000, 4'h0);
        check({stack_pointer, program_counter}, 12'h000);
        issue(`STME_OP_RET, 10'h000, 4'h0);
        chk_rst;
        issue(`STME_OP_CALL, 10'h111, 4'h0);
        issue(`STME_OP_CALL, 10'h222, 4'h0);
        chk_rst;
    endtask
    task automatic t_timer;
        issue(`STME_OP_LD_TIMM, 10'h3c5, 4'h0);
        check({seen_rl, timer_reg}, 11'h7c5);
        check(timer_interval_clks, 18'h0f180);
        issue(`STME_OP_RD_THI, 10'h000, 4'h0);
        check({seen_we, acc_out}, 5'h1f);
        issue(`STME_OP_RD_TLO, 10'h000, 4'h0);
        check({seen_we, acc_out}, 5'h11);
        issue(`STME_OP_WR_THI, 10'h000, 4'h5);
        check(timer_reg, 10'h145);
        issue(`STME_OP_WR_TLO, 10'h000, 4'ha);
        check({seen_rl, timer_reg}, 11'h568);
        issue(`STME_OP_LD_TTBL, 10'h2b7, 4'h0);
        check({rom_addr, timer_reg}, 21'h1672b7);
    endtask
    task automatic t_misc;
        logic [3:0] v [6] = '{4'h0, 4'h1, 4'h3, 4'h7, 4'hf, 4'he};
        int n;
        foreach (v[i])
        begin
            issue(`STME_OP_ALL_ONES_TEST_OP, 10'h000, v[i]);
            check(carry_flag, v[i] == 4'hf);
        end
        @(posedge sys_clk);
        status_in <= 4'h4;
        timer_clk_slow <= 1'b1;
        issue(`STME_OP_STATUS_TEST_OP_IMM, 10'h00c, 4'h0);
        check(status_flag, 1'b1);
        check(timer_interval_clks, 18'h15c00);
        issue(`STME_OP_STATUS_TEST_OP_REG, 10'h000, 4'hb);
        check(status_flag, 1'b0);
        issue(`STME_OP_HALT, 10'h006, 4'h0);
        check({standby, wake_sel}, 5'h16);
        @(posedge sys_clk);
        req_valid <= 1'b1;
        n = 0;
        repeat (12)
        begin
            @(posedge sys_clk);
            #1;
            n += req_taken;
        end
        check(n, 0);
        @(posedge sys_clk);
        wake_event <= 1'b1;
        issue(`STME_OP_NOP, 10'h000, 4'h0);
        check(standby, 1'b0);
    endtask
    // =========================================
    // main sequence
    initial
    begin
        repeat (3) @(posedge sys_clk);
        srst <= 1'b0;
        t_stack;
        t_timer;
        t_misc;
        close_out;
    end
    // watchdog: the run needs well under a thousand cycles
    initial
    begin
        #100000;
        error_cnt++;
        close_out;
    end
endmodule
`default_nettype wire
